// File: pkg/serial_port_pkg.sv
package serial_port_pkg;
  // Register indices on the plain port
  localparam logic [2:0] ADDR_FLAGS    = 3'h0;
  localparam logic [2:0] ADDR_IRQ_EN   = 3'h1;
  localparam logic [2:0] ADDR_IRQ_PRI  = 3'h2;
  localparam logic [2:0] ADDR_RX_CTRL  = 3'h3;
  localparam logic [2:0] ADDR_RX_BUF   = 3'h4;
  localparam logic [2:0] ADDR_TX_CTRL  = 3'h5;
  localparam logic [2:0] ADDR_BAUD_DIV = 3'h6;
  localparam logic [2:0] ADDR_TX_BUF   = 3'h7;
  // Flag / enable register bit positions
  localparam int BIT_RX_FLAG = 5;
  localparam int BIT_TX_FLAG = 4;
  // Receive status/control bit positions
  localparam int BIT_SERIAL_PORT_ENABLE  = 7;
  localparam int BIT_RX9   = 6;
  localparam int BIT_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int BIT_ADDRESS_DETECT_ENABLE = 3;
  localparam int BIT_FRAMING_ERROR_FLAG  = 2;
  localparam int BIT_OVERRUN_ERROR_FLAG  = 1;
  localparam int BIT_RECEIVED_NINTH_BIT_VALUE  = 0;
  // Transmit status/control bit positions
  localparam int BIT_CLOCK_SOURCE_MASTER_SELECT  = 7;
  localparam int BIT_TX9   = 6;
  localparam int BIT_TRANSMIT_ENABLE_BIT  = 5;
  localparam int BIT_SYNC  = 4;
  localparam int BIT_HIGH_SPEED_BAUD_SELECT  = 2;
  localparam int BIT_SHIFTER_EMPTY_STATUS  = 1;
  localparam int BIT_TRANSMIT_NINTH_BIT_VALUE  = 0;
  // Reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_TX_CTRL = 8'h02;
  // Oversampling
  localparam logic [5:0] OVS_LOW   = 6'h0F;
  localparam logic [5:0] OVS_HIGH  = 6'h3F;
  localparam logic [3:0] RX_SAMPLE = 4'h7;
  localparam logic [3:0] BITS_8    = 4'h8;
  localparam logic [3:0] BITS_9    = 4'h9;
endpackage

// File: design/baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] divisor,
  // Tick out
  output logic            tick
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  // Divide by divisor+1; counter held loaded with divisor when not running
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_cnt = divisor;
    end else if (cnt_ff == 8'h00) begin
      nxt_cnt  = divisor;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule

// File: design/serial_port_rx_and_sync_master.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module serial_port_rx_and_sync_master
  import serial_port_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  // Register port
  input  wire logic [2:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Receive pin, also sync data line
  input  wire logic       RX_PIN_IN,
  output logic            RX_PIN_OUT,
  output logic            RX_PIN_OE,
  // Transmit pin, also sync shift clock line
  input  wire logic       TX_PIN_IN,
  output logic            TX_PIN_OUT,
  output logic            TX_PIN_OE,
  // Interrupt requests
  output logic            RX_IRQ,
  output logic            TX_IRQ
);
  import serial_port_pkg::*;

  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP, ST_SRX, ST_STX} state_e;

  // Register state
  logic [7:0] irq_en_ff, irq_pri_ff, rx_ctrl_ff, tx_ctrl_ff, div_ff, txbuf_ff, rxbuf_ff;
  logic [7:0] nxt_irq_en, nxt_irq_pri, nxt_rx_ctrl, nxt_tx_ctrl, nxt_div, nxt_txbuf, nxt_rxbuf;
  logic       txfull_ff, nxt_txfull, rxfull_ff, nxt_rxfull, rxflag_ff, nxt_rxflag;
  logic [7:0] rdata_ff, nxt_rdata;
  // Engine state
  state_e     st_ff, nxt_st;
  logic [8:0] sh_ff, nxt_sh;
  logic [3:0] bit_ff, nxt_bit;
  logic [5:0] ovs_ff, nxt_ovs;
  logic       ck_ff, nxt_ck, dt_ff, nxt_dt, dt_oe_ff, nxt_dt_oe;
  logic       ck_oe_ff, nxt_ck_oe, txline_ff, nxt_txline;
  logic       loaded_ff, nxt_loaded;
  // Pin synchronisers
  logic [1:0] rx_sync_ff, ck_sync_ff;
  logic       ck_prev_ff;
  logic       irq_rx_ff, irq_tx_ff;

  wire logic serial_port_enable  = rx_ctrl_ff[BIT_SERIAL_PORT_ENABLE];
  wire logic sync  = tx_ctrl_ff[BIT_SYNC];
  wire logic mastr = tx_ctrl_ff[BIT_CLOCK_SOURCE_MASTER_SELECT];
  wire logic nine  = rx_ctrl_ff[BIT_RX9];
  wire logic continuous_receive_enable  = rx_ctrl_ff[BIT_CONTINUOUS_RECEIVE_ENABLE];
  wire logic single_receive_enable  = rx_ctrl_ff[BIT_SINGLE_RECEIVE_ENABLE];
  wire logic rx_s  = rx_sync_ff[1];
  wire logic ck_s  = ck_sync_ff[1];
  wire logic tick;
  wire logic ovs_wrap = tick && (ovs_ff == (tx_ctrl_ff[BIT_HIGH_SPEED_BAUD_SELECT] ? OVS_LOW : OVS_HIGH));
  wire logic ovs_mid  = tick && (ovs_ff[3:0] == RX_SAMPLE) && tx_ctrl_ff[BIT_HIGH_SPEED_BAUD_SELECT];
  wire logic ovs_mid_l = tick && (ovs_ff == {2'b01, 4'hF});
  wire logic sample   = ovs_mid || (!tx_ctrl_ff[BIT_HIGH_SPEED_BAUD_SELECT] && ovs_mid_l);
  wire logic slave_rise = !mastr && ck_s && !ck_prev_ff;
  wire logic slave_fall = !mastr && !ck_s && ck_prev_ff;
  wire logic wr_txbuf   = REG_WR && (REG_ADDR == ADDR_TX_BUF);
  wire logic rd_rxbuf   = REG_RD && (REG_ADDR == ADDR_RX_BUF);
  wire logic [3:0] nbits = nine ? BITS_9 : BITS_8;

  baud_tick_gen u_baud (
    .clk     (CORE_CLK),
    .rst_n   (RSTN),
    .run     (serial_port_enable),
    .divisor (div_ff),
    .tick    (tick)
  );

  // Register file: software side
  always_comb begin
    nxt_irq_en  = irq_en_ff;
    nxt_irq_pri = irq_pri_ff;
    nxt_rx_ctrl = rx_ctrl_ff;
    nxt_tx_ctrl = tx_ctrl_ff;
    nxt_div     = div_ff;
    nxt_rdata   = 8'h00;
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_IRQ_EN:   nxt_irq_en  = REG_WDATA & 8'h30;
        ADDR_IRQ_PRI:  nxt_irq_pri = REG_WDATA & 8'h30;
        ADDR_RX_CTRL:  nxt_rx_ctrl = {REG_WDATA[7:3], rx_ctrl_ff[2:0]};
        // Shifter-empty bit stays hardware owned
        ADDR_TX_CTRL:  nxt_tx_ctrl = {REG_WDATA[7:4], 1'b0, REG_WDATA[2], tx_ctrl_ff[1],
                                      REG_WDATA[0]};
        ADDR_BAUD_DIV: nxt_div     = REG_WDATA;
        default: ;
      endcase
    end
    // Errors vanish with continuous receive cleared
    if (!nxt_rx_ctrl[BIT_CONTINUOUS_RECEIVE_ENABLE]) begin
      nxt_rx_ctrl[BIT_OVERRUN_ERROR_FLAG] = 1'b0;
      nxt_rx_ctrl[BIT_FRAMING_ERROR_FLAG] = 1'b0;
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_FLAGS:    nxt_rdata = {2'b00, rxflag_ff, !txfull_ff && tx_ctrl_ff[BIT_TRANSMIT_ENABLE_BIT],
                                    4'h0};
        ADDR_IRQ_EN:   nxt_rdata = irq_en_ff;
        ADDR_IRQ_PRI:  nxt_rdata = irq_pri_ff;
        ADDR_RX_CTRL:  nxt_rdata = rx_ctrl_ff;
        ADDR_RX_BUF:   nxt_rdata = rxbuf_ff;
        ADDR_TX_CTRL:  nxt_rdata = {tx_ctrl_ff[7:2], !loaded_ff, tx_ctrl_ff[0]};
        ADDR_BAUD_DIV: nxt_rdata = div_ff;
        ADDR_TX_BUF:   nxt_rdata = txbuf_ff;
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end

  // Serial engine
  always_comb begin
    nxt_st     = st_ff;
    nxt_sh     = sh_ff;
    nxt_bit    = bit_ff;
    nxt_ovs    = tick ? ovs_ff + 6'h01 : ovs_ff;
    nxt_ck     = ck_ff;
    nxt_dt     = dt_ff;
    nxt_dt_oe  = 1'b0;
    nxt_ck_oe  = serial_port_enable && sync && mastr;
    nxt_txline = 1'b1;
    nxt_loaded = loaded_ff;
    nxt_txbuf  = wr_txbuf ? REG_WDATA : txbuf_ff;
    nxt_txfull = txfull_ff || wr_txbuf;
    nxt_rxbuf  = rxbuf_ff;
    nxt_rxfull = rxfull_ff && !rd_rxbuf;
    nxt_rxflag = rxflag_ff && !rd_rxbuf;
    if (ovs_wrap) begin
      nxt_ovs = 6'h00;
    end
    if (!serial_port_enable) begin
      nxt_st     = ST_IDLE;
      nxt_loaded = 1'b0;
      nxt_ck     = 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          nxt_ck = 1'b0;
          // Half duplex: a pending word goes before any receive
          if (sync && txfull_ff && tx_ctrl_ff[BIT_TRANSMIT_ENABLE_BIT]) begin
            nxt_sh     = {tx_ctrl_ff[BIT_TRANSMIT_NINTH_BIT_VALUE], txbuf_ff};
            nxt_txfull = wr_txbuf;
            nxt_loaded = 1'b1;
            nxt_bit    = 4'h0;
            nxt_st     = ST_STX;
          end else if (sync && (continuous_receive_enable || single_receive_enable)) begin
            nxt_bit = 4'h0;
            nxt_st  = ST_SRX;
          end else if (!sync && continuous_receive_enable && !rx_s) begin
            nxt_ovs = 6'h00;
            nxt_st  = ST_START;
          end
        end
        ST_START: begin
          if (sample) begin
            nxt_st  = rx_s ? ST_IDLE : ST_DATA;
            nxt_bit = 4'h0;
          end
        end
        ST_DATA: begin
          if (sample) begin
            nxt_sh  = {rx_s, sh_ff[8:1]};
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff + 4'h1 == nbits) begin
              nxt_st = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (sample) begin
            nxt_st = ST_IDLE;
          end
        end
        ST_SRX, ST_STX: begin
          // Master toggles clock per tick; slave follows synced pin edges
          if ((mastr && tick) || slave_rise || slave_fall) begin
            nxt_ck = mastr ? !ck_ff : ck_s;
            if (st_ff == ST_STX) begin
              nxt_dt_oe = 1'b1;
              if (nxt_ck) begin
                nxt_dt = sh_ff[0];
              end else begin
                nxt_sh  = {1'b0, sh_ff[8:1]};
                nxt_bit = bit_ff + 4'h1;
                if (bit_ff + 4'h1 == (tx_ctrl_ff[BIT_TX9] ? BITS_9 : BITS_8)) begin
                  // Reload only once the final bit has left
                  nxt_loaded = 1'b0;
                  nxt_st     = ST_IDLE;
                end
              end
            end else if (!nxt_ck) begin
              nxt_sh  = {rx_s, sh_ff[8:1]};
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff + 4'h1 == nbits) begin
                nxt_st = ST_IDLE;
              end
            end
          end else if (st_ff == ST_STX) begin
            nxt_dt_oe = 1'b1;
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
    if (st_ff == ST_STX) begin
      nxt_dt_oe = serial_port_enable;
    end
    // Word complete: address filter, then load and flag
    if ((st_ff == ST_STOP && sample) ||
        (st_ff == ST_SRX && nxt_st == ST_IDLE && serial_port_enable)) begin
      if ((!(nine && rx_ctrl_ff[BIT_ADDRESS_DETECT_ENABLE] && !nxt_sh[8] && !sync) || sync) &&
          !(st_ff == ST_STOP && rxfull_ff && !rd_rxbuf)) begin
        nxt_rxbuf  = nine ? nxt_sh[7:0] : nxt_sh[8:1];
        nxt_rxfull = 1'b1;
        nxt_rxflag = 1'b1;
      end
    end
  end

  // Hardware-owned status bits; the hardware update wins over a software write in the same cycle
  logic [7:0] rx_ctrl_hw;
  always_comb begin
    rx_ctrl_hw = nxt_rx_ctrl;
    if (st_ff == ST_STOP && sample && continuous_receive_enable) begin
      rx_ctrl_hw[BIT_FRAMING_ERROR_FLAG] = !rx_s;
      rx_ctrl_hw[BIT_RECEIVED_NINTH_BIT_VALUE] = nine && sh_ff[8];
      if (rxfull_ff && !rd_rxbuf) begin
        rx_ctrl_hw[BIT_OVERRUN_ERROR_FLAG] = 1'b1;
      end
    end
    if (st_ff == ST_SRX && nxt_st == ST_IDLE) begin
      rx_ctrl_hw[BIT_RECEIVED_NINTH_BIT_VALUE] = nine && nxt_sh[8];
      if (!continuous_receive_enable) begin
        rx_ctrl_hw[BIT_SINGLE_RECEIVE_ENABLE] = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_en_ff  <= RST_ZERO;
      irq_pri_ff <= RST_ZERO;
      rx_ctrl_ff <= RST_ZERO;
      tx_ctrl_ff <= RST_TX_CTRL;
      div_ff     <= RST_ZERO;
      txbuf_ff   <= RST_ZERO;
      rxbuf_ff   <= RST_ZERO;
      txfull_ff  <= 1'b0;
      rxfull_ff  <= 1'b0;
      rxflag_ff  <= 1'b0;
      rdata_ff   <= RST_ZERO;
      st_ff      <= ST_IDLE;
      sh_ff      <= 9'h000;
      bit_ff     <= 4'h0;
      ovs_ff     <= 6'h00;
      ck_ff      <= 1'b0;
      dt_ff      <= 1'b1;
      dt_oe_ff   <= 1'b0;
      ck_oe_ff   <= 1'b0;
      txline_ff  <= 1'b1;
      loaded_ff  <= 1'b0;
      rx_sync_ff <= 2'b11;
      ck_sync_ff <= 2'b00;
      ck_prev_ff <= 1'b0;
      irq_rx_ff  <= 1'b0;
      irq_tx_ff  <= 1'b0;
    end else begin
      irq_en_ff  <= nxt_irq_en;
      irq_pri_ff <= nxt_irq_pri;
      rx_ctrl_ff <= rx_ctrl_hw;
      tx_ctrl_ff <= {nxt_tx_ctrl[7:2], !nxt_loaded, nxt_tx_ctrl[0]};
      div_ff     <= nxt_div;
      txbuf_ff   <= nxt_txbuf;
      rxbuf_ff   <= nxt_rxbuf;
      txfull_ff  <= nxt_txfull;
      rxfull_ff  <= nxt_rxfull;
      rxflag_ff  <= nxt_rxflag;
      rdata_ff   <= nxt_rdata;
      st_ff      <= nxt_st;
      sh_ff      <= nxt_sh;
      bit_ff     <= nxt_bit;
      ovs_ff     <= nxt_ovs;
      ck_ff      <= nxt_ck;
      dt_ff      <= nxt_dt;
      dt_oe_ff   <= nxt_dt_oe;
      ck_oe_ff   <= nxt_ck_oe;
      txline_ff  <= nxt_txline;
      loaded_ff  <= nxt_loaded;
      // Two-flop synchronisers for both pins
      rx_sync_ff <= {rx_sync_ff[0], RX_PIN_IN};
      ck_sync_ff <= {ck_sync_ff[0], TX_PIN_IN};
      ck_prev_ff <= ck_s;
      irq_rx_ff  <= nxt_rxflag && nxt_irq_en[BIT_RX_FLAG];
      irq_tx_ff  <= !nxt_txfull && nxt_tx_ctrl[BIT_TRANSMIT_ENABLE_BIT] && nxt_irq_en[BIT_TX_FLAG];
    end
  end

  // Pin muxing: sync mode turns transmit pin into clock, receive pin into data
  assign REG_RDATA  = rdata_ff;
  assign TX_PIN_OUT = ck_ff;
  assign TX_PIN_OE  = ck_oe_ff;
  assign RX_PIN_OUT = dt_ff;
  assign RX_PIN_OE  = dt_oe_ff;
  assign RX_IRQ     = irq_rx_ff;
  assign TX_IRQ     = irq_tx_ff;
endmodule

// File: verification/serial_port_asserts.sv
`timescale 1ns/1ps
module serial_port_asserts
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  // Register port
  input wire logic [2:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Pins and requests
  input wire logic       RX_PIN_OUT,
  input wire logic       RX_PIN_OE,
  input wire logic       TX_PIN_OUT,
  input wire logic       TX_PIN_OE,
  input wire logic       RX_IRQ,
  input wire logic       TX_IRQ
);
  // Any strobe; request lines only drop because software touched something
  logic bus_act;
  assign bus_act = REG_WR | REG_RD;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // Read data only in the slot after a read
  a_rdata_idle: assert property (
    !$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("read data outside its slot");
  a_buf_read_clear: assert property (
    REG_RD && REG_ADDR == ADDR_RX_BUF |-> ##[1:3] !RX_IRQ) else $error("receive request held");
  a_rx_irq_cause: assert property (
    $fell(RX_IRQ) |-> $past(bus_act) || $past(bus_act, 2) || $past(bus_act, 3))
    else $error("receive request dropped by itself");
  a_tx_irq_cause: assert property (
    $fell(TX_IRQ) |-> $past(REG_WR) || $past(REG_WR, 2) || $past(REG_WR, 3))
    else $error("buffer empty dropped without a write");
  a_oe_pair: assert property (
    RX_PIN_OE |-> TX_PIN_OE) else $error("data driven without master clock");
  // Data must never move at the clock edge the far side samples on
  a_data_at_rise: assert property (
    RX_PIN_OE && $past(RX_PIN_OE) && $changed(RX_PIN_OUT) |-> !$fell(TX_PIN_OUT))
    else $error("data changed on falling clock");
  a_clk_oe_cause: assert property (
    $rose(TX_PIN_OE) |-> $past(REG_WR) || $past(REG_WR, 2) || $past(REG_WR, 3))
    else $error("clock pin driven without a mode write");
  a_reset_quiet: assert property (disable iff (1'b0)
    !RSTN |-> !RX_PIN_OE && !TX_PIN_OE && !RX_IRQ && !TX_IRQ) else $error("active in reset");
endmodule

bind serial_port_rx_and_sync_master serial_port_asserts chk_u (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .RX_PIN_OUT(RX_PIN_OUT), .RX_PIN_OE(RX_PIN_OE),
  .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_OE(TX_PIN_OE), .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ)
);

// File: verification/serial_peer_model.sv
`timescale 1ns/1ps
module serial_peer_model (
  // Line side
  input  wire logic clk_line,
  input  wire logic data_line,
  input  wire logic dev_drives,
  output logic      peer_data
);
  logic [7:0] pat;
  logic       sync_on;
  logic       armed;
  logic       got [$];
  // Idle line rests at mark, like a pulled-up RS-232 receiver input
  initial begin
    peer_data = 1'b1;
    sync_on = 1'b0;
    armed = 1'b0;
  end
  // Start bit, data least significant first, then the stop level asked for
  task automatic send_word(input logic [8:0] w, input logic nine, input logic stop,
                           input int bit_ns);
    peer_data = 1'b0;
    #bit_ns;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      peer_data = w[i];
      #bit_ns;
    end
    peer_data = stop;
    #bit_ns;
    peer_data = 1'b1;
  endtask
  task automatic arm(input logic [7:0] p);
    pat = p;
    peer_data = p[0];
    sync_on = 1'b1;
  endtask
  // Next bit appears well after the falling sample, so it is held across it
  always @(negedge clk_line) begin
    if (sync_on && !dev_drives) begin
      #100;
      pat = {pat[0], pat[7:1]};
      peer_data = pat[0];
    end
  end
  // Bits from a master are taken on the falling edge of its clock
  always @(posedge clk_line) armed = dev_drives;
  always @(negedge clk_line) if (armed) got.push_back(data_line);
endmodule

// File: verification/serial_port_rx_and_sync_master_tb_top.sv
`timescale 1ns/1ps
module serial_port_rx_and_sync_master_tb_top;
  import serial_port_pkg::*;
  logic       core_clk;
  logic       rstn;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx_out, rx_oe, tx_out, tx_oe, rx_irq, tx_irq;
  logic       peer_data;
  logic       slave_clk;
  int         n_fail;
  int         total_checks;
  // Wire levels worked out from the device's output enables
  wire rx_line = rx_oe ? rx_out : peer_data;
  wire tx_line = tx_oe ? tx_out : slave_clk;

  serial_port_rx_and_sync_master dut_u (
    .CORE_CLK(core_clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RX_PIN_IN(rx_line),
    .RX_PIN_OUT(rx_out), .RX_PIN_OE(rx_oe), .TX_PIN_IN(tx_line), .TX_PIN_OUT(tx_out),
    .TX_PIN_OE(tx_oe), .RX_IRQ(rx_irq), .TX_IRQ(tx_irq)
  );
  serial_peer_model peer_u (
    .clk_line(tx_line), .data_line(rx_line), .dev_drives(rx_oe), .peer_data(peer_data)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is taken mid-cycle in the one slot where it stands
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, exp);
  endtask
  // Polls a status bit with a bounded count; giving up is a mismatch
  task automatic wait_bit(input logic [2:0] a, input int b);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 3000 && d[b] !== 1'b1; i++) rd(a, d);
    chk({7'h00, d[b]}, 8'h01);
  endtask
  task automatic async_on(input logic [7:0] rxc, input logic hs);
    wr(ADDR_BAUD_DIV, 8'h00);
    wr(ADDR_TX_CTRL, {5'h00, hs, 2'h0});
    wr(ADDR_RX_CTRL, rxc);
  endtask
  task automatic t_regs();
    rc(ADDR_FLAGS, 8'hFF, RST_ZERO);
    rc(ADDR_RX_CTRL, 8'hFF, RST_ZERO);
    rc(ADDR_TX_CTRL, 8'hFF, RST_TX_CTRL);
    wr(ADDR_FLAGS, 8'hFF);
    rc(ADDR_FLAGS, 8'hFF, 8'h00);
    wr(ADDR_TX_CTRL, 8'h00);
    rc(ADDR_TX_CTRL, 8'h02, 8'h02);
    wr(ADDR_IRQ_PRI, 8'h30);
    rc(ADDR_IRQ_PRI, 8'h30, 8'h30);
  endtask
  task automatic t_async();
    async_on(8'h90, 1'b1);
    peer_u.send_word(9'h0A5, 1'b0, 1'b1, 800);
    wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
    chk({7'h00, rx_irq}, 8'h00);
    wr(ADDR_IRQ_EN, 8'h20);
    repeat (3) @(posedge core_clk);
    chk({7'h00, rx_irq}, 8'h01);
    rc(ADDR_RX_CTRL, 8'h07, 8'h00);
    rc(ADDR_RX_BUF, 8'hFF, 8'hA5);
    peer_u.send_word(9'h03C, 1'b0, 1'b0, 800);
    wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
    rc(ADDR_RX_CTRL, 8'h06, 8'h04);
    rc(ADDR_RX_BUF, 8'hFF, 8'h3C);
    // Second word arrives while the first is unread
    peer_u.send_word(9'h011, 1'b0, 1'b1, 800);
    peer_u.send_word(9'h022, 1'b0, 1'b1, 800);
    repeat (40) @(posedge core_clk);
    rc(ADDR_RX_CTRL, 8'h02, 8'h02);
    wr(ADDR_RX_CTRL, 8'h80);
    rc(ADDR_RX_CTRL, 8'h06, 8'h00);
    rc(ADDR_RX_BUF, 8'hFF, 8'h11);
    wr(ADDR_IRQ_EN, 8'h00);
    async_on(8'h90, 1'b0);
    peer_u.send_word(9'h0C6, 1'b0, 1'b1, 3200);
    wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
    rc(ADDR_RX_BUF, 8'hFF, 8'hC6);
  endtask
  task automatic t_addr();
    async_on(8'hC8, 1'b1);
    wr(ADDR_RX_CTRL, 8'hD8);
    peer_u.send_word(9'h055, 1'b1, 1'b1, 800);
    peer_u.send_word(9'h142, 1'b1, 1'b1, 800);
    wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
    rc(ADDR_RX_CTRL, 8'h07, 8'h01);
    rc(ADDR_RX_BUF, 8'hFF, 8'h42);
    wr(ADDR_RX_CTRL, 8'hD0);
    peer_u.send_word(9'h033, 1'b1, 1'b1, 800);
    wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
    rc(ADDR_RX_CTRL, 8'h07, 8'h00);
    rc(ADDR_RX_BUF, 8'hFF, 8'h33);
    wr(ADDR_RX_CTRL, 8'h00);
  endtask
  task automatic t_sync_tx();
    logic [15:0] exp;
    exp = 16'h963C;
    wr(ADDR_BAUD_DIV, 8'h07);
    wr(ADDR_RX_CTRL, 8'h80);
    wr(ADDR_TX_CTRL, 8'hB0);
    wr(ADDR_IRQ_EN, 8'h10);
    repeat (3) @(posedge core_clk);
    chk({6'h00, tx_oe, tx_irq}, 8'h03);
    wr(ADDR_TX_BUF, 8'h3C);
    wr(ADDR_TX_BUF, 8'h96);
    rc(ADDR_TX_CTRL, 8'h02, 8'h00);
    rc(ADDR_FLAGS, 8'h10, 8'h00);
    wait_bit(ADDR_FLAGS, BIT_TX_FLAG);
    wait_bit(ADDR_TX_CTRL, BIT_SHIFTER_EMPTY_STATUS);
    repeat (20) @(posedge core_clk);
    chk(8'(peer_u.got.size()), 8'h10);
    for (int i = 0; i < 16 && i < peer_u.got.size(); i++) begin
      chk({7'h00, peer_u.got[i]}, {7'h00, exp[i]});
    end
    wr(ADDR_TX_CTRL, 8'h90);
    wr(ADDR_IRQ_EN, 8'h00);
  endtask
  task automatic t_sync_rx();
    peer_u.arm(8'hC3);
    rc(ADDR_RX_CTRL, 8'h30, 8'h00);
    wr(ADDR_RX_CTRL, 8'hA0);
    wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
    chk({7'h00, rx_oe}, 8'h00);
    rc(ADDR_RX_CTRL, 8'h20, 8'h00);
    rc(ADDR_RX_BUF, 8'hFF, 8'hC3);
    repeat (300) @(posedge core_clk);
    rc(ADDR_FLAGS, 8'h20, 8'h00);
    peer_u.arm(8'h5A);
    wr(ADDR_RX_CTRL, 8'hB0);
    repeat (2) begin
      wait_bit(ADDR_FLAGS, BIT_RX_FLAG);
      rc(ADDR_RX_BUF, 8'hFF, 8'h5A);
    end
    wr(ADDR_RX_CTRL, 8'h80);
  endtask
  // Slave: the far side clocks at its own rate, stopped outside the word
  task automatic t_slave();
    // Drop the port first so no word left over from master mode is mid-flight
    wr(ADDR_RX_CTRL, 8'h00);
    peer_u.arm(8'hA6);
    wr(ADDR_TX_CTRL, 8'h10);
    wr(ADDR_RX_CTRL, 8'h90);
    repeat (3) @(posedge core_clk);
    chk({6'h00, tx_oe, rx_oe}, 8'h00);
    #10;
    repeat (8) begin
      slave_clk = 1'b0;
      #200;
      slave_clk = 1'b1;
      #200;
    end
    repeat (4) @(posedge core_clk);
    rc(ADDR_FLAGS, 8'h20, 8'h20);
    rc(ADDR_RX_BUF, 8'hFF, 8'hA6);
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slave_clk = 1'b1;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_async();
    t_addr();
    t_sync_tx();
    t_sync_rx();
    t_slave();
    finish_test();
  end
endmodule
